// ===== rtl/ana_cfg.svh
// Offsets, field positions, reset values and timing counts of the advertisement block
`ifndef ANA_CFG_SVH
`define ANA_CFG_SVH
`define ANA_ADV_INDEX 8'h04
`define ANA_ADV_ADDR 12'h010
`define ANA_CTRL_INDEX 8'h00
`define ANA_CTRL_ADDR 12'h000
`define ANA_ADV_RESET 16'h01e1
`define ANA_ADV_WMASK 16'h21e0
`define ANA_SEL_VALUE 5'h01
`define ANA_TECH_HI 8
`define ANA_TECH_LO 5
`define ANA_RF_BIT 13
`define ANA_NP_BIT 15
`define ANA_RESTART_BIT 9
`define ANA_RESTART_CYCLES 2
`endif

// ===== rtl/ana_pkg.sv
// Types of the advertisement block
package ana_pkg;
  typedef enum logic [1:0] {
    ANA_IDLE = 2'b01,
    ANA_LOAD = 2'b10
  } ana_state_t;
endpackage

// ===== rtl/ana_hold_reg.sv
`timescale 1ns/1ps
// Loadable register with constant reset value
module ana_hold_reg #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // Elaboration-time refusal of an empty register
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be positive");
  end
  logic [WIDTH-1:0] val_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_q <= RESET_VALUE;
    end else if (load) begin
      val_q <= din;
    end
  end
  assign dout = val_q;
endmodule

// ===== rtl/ana_adv_regs.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
// Auto-negotiation advertisement register with APB access
// Operation
// - Advertisement register at index 0x04, 16 bits, reset value 0x01e1.
// - Bits 8:5 hold the technology ability field, writable by software.
// - Written abilities reach the partner only after an autoneg restart.
// - Bits 8,7,6,5 advertise 100TX full, 100TX half, 10T full, 10T half.
// - Selector bits 4:0 are read-only and fixed at 1.
`include "ana_cfg.svh"
module ana_adv_regs
  import ana_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [15:0] ADV_ACTIVE,
  output logic ADV_100TX_FULL,
  output logic ADV_100TX_HALF,
  output logic ADV_10T_FULL,
  output logic ADV_10T_HALF,
  output logic REMOTE_FAULT_ADVERT,
  output logic RESTART_AUTONEG
);
  localparam logic [15:0] ADV_RESET = `ANA_ADV_RESET;
  localparam logic [15:0] ADV_WMASK = `ANA_ADV_WMASK;

  logic [15:0] staged;
  logic [15:0] active;
  logic [15:0] staged_next;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic pready_q;
  logic pslverr_q;
  logic restart_q;
  ana_state_t state_q;
  ana_state_t state_d;

  wire setup = PSEL && !PENABLE;
  wire hit_adv = PADDR == `ANA_ADV_ADDR;
  wire hit_ctrl = PADDR == `ANA_CTRL_ADDR;
  wire mapped = hit_adv || hit_ctrl;
  wire wr_adv = setup && PWRITE && hit_adv;
  wire restart_req = setup && PWRITE && hit_ctrl && PWDATA[`ANA_RESTART_BIT];

  // Writable bits only, selector forced
  assign staged_next = (PWDATA[15:0] & ADV_WMASK) | {11'h000, `ANA_SEL_VALUE};

  ana_hold_reg #(.WIDTH(16), .RESET_VALUE(ADV_RESET)) u_staged (
    .clk(CLOCK),
    .rst_n(RSTN),
    .load(wr_adv),
    .din(staged_next),
    .dout(staged)
  );

  // Offered set follows staged only on restart
  ana_hold_reg #(.WIDTH(16), .RESET_VALUE(ADV_RESET)) u_active (
    .clk(CLOCK),
    .rst_n(RSTN),
    .load(state_q == ANA_LOAD),
    .din(staged),
    .dout(active)
  );

  always_comb begin
    case (state_q)
      ANA_IDLE: state_d = restart_req ? ANA_LOAD : ANA_IDLE;
      ANA_LOAD: state_d = ANA_IDLE;
      default: state_d = ANA_IDLE;
    endcase
  end

  assign rdata_d = hit_adv ? {16'h0000, staged} : 32'h0000_0000;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ANA_IDLE;
      rdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rdata_q <= setup ? rdata_d : rdata_q;
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      restart_q <= state_q == ANA_LOAD;
    end
  end

  assign PRDATA = rdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign RESTART_AUTONEG = restart_q;
  assign ADV_ACTIVE = active;
  // Ability decode
  assign ADV_100TX_FULL = active[8];
  assign ADV_100TX_HALF = active[7];
  assign ADV_10T_FULL = active[6];
  assign ADV_10T_HALF = active[5];
  assign REMOTE_FAULT_ADVERT = active[`ANA_RF_BIT];

  property p_sel_fixed;
    @(posedge CLOCK) disable iff (!RSTN) staged[4:0] == `ANA_SEL_VALUE;
  endproperty
  a_sel_fixed: assert property (p_sel_fixed) else $error("selector not 1");

  property p_rsvd_zero;
    @(posedge CLOCK) disable iff (!RSTN) (staged & ~ADV_WMASK) == 16'h0001;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  property p_write_stores;
    @(posedge CLOCK) disable iff (!RSTN) wr_adv |=> staged == $past(staged_next);
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("write lost");

  property p_no_restart_hold;
    @(posedge CLOCK) disable iff (!RSTN) state_q != ANA_LOAD |=> $stable(active);
  endproperty
  a_no_restart_hold: assert property (p_no_restart_hold) else $error("early change");

  property p_restart_loads;
    @(posedge CLOCK) disable iff (!RSTN)
      restart_req && !wr_adv |-> ##2 active == $past(staged, 2);
  endproperty
  a_restart_loads: assert property (p_restart_loads) else $error("restart no load");

  property p_ability_map;
    @(posedge CLOCK) disable iff (!RSTN)
      {ADV_100TX_FULL, ADV_100TX_HALF, ADV_10T_FULL, ADV_10T_HALF} == active[8:5];
  endproperty
  a_ability_map: assert property (p_ability_map) else $error("ability map");

  property p_reset_value;
    @(posedge CLOCK) $rose(RSTN) |-> staged == ADV_RESET && active == ADV_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad reset");

  property p_read_back;
    @(posedge CLOCK) disable iff (!RSTN)
      setup && !PWRITE && hit_adv |=> PREADY && PRDATA[15:0] == $past(staged);
  endproperty
  a_read_back: assert property (p_read_back) else $error("bad readback");


  // Bus answer timing and refusals
  property p_ready_follows_setup;
    @(posedge CLOCK) disable iff (!RSTN) setup |=> PREADY;
  endproperty
  a_ready_follows_setup: assert property (p_ready_follows_setup) else $error("no ready");

  property p_err_unmapped;
    @(posedge CLOCK) disable iff (!RSTN) setup && !mapped |=> PSLVERR;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("no slave error");

  property p_unmapped_write_ignored;
    @(posedge CLOCK) disable iff (!RSTN) setup && PWRITE && !mapped |=> $stable(staged);
  endproperty
  a_unmapped_write_ignored: assert property (p_unmapped_write_ignored) else $error("stray write");

  property p_read_other_zero;
    @(posedge CLOCK) disable iff (!RSTN) setup && !PWRITE && !hit_adv |=> PRDATA == 32'h0000_0000;
  endproperty
  a_read_other_zero: assert property (p_read_other_zero) else $error("other read not zero");

  // Restart strobe is a single cycle tied to a control write
  property p_restart_pulse;
    @(posedge CLOCK) disable iff (!RSTN) RESTART_AUTONEG |=> !RESTART_AUTONEG;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart too long");

  property p_restart_cause;
    @(posedge CLOCK) disable iff (!RSTN) $rose(RESTART_AUTONEG) |-> $past(restart_req, 2);
  endproperty
  a_restart_cause: assert property (p_restart_cause) else $error("restart uncaused");

  property p_rf_map;
    @(posedge CLOCK) disable iff (!RSTN) REMOTE_FAULT_ADVERT == active[`ANA_RF_BIT];
  endproperty
  a_rf_map: assert property (p_rf_map) else $error("remote fault map");

  c_write: cover property (@(posedge CLOCK) disable iff (!RSTN) wr_adv);
  c_read: cover property (@(posedge CLOCK) disable iff (!RSTN) setup && !PWRITE && hit_adv);
  c_restart: cover property (@(posedge CLOCK) disable iff (!RSTN) RESTART_AUTONEG);
  c_err: cover property (@(posedge CLOCK) disable iff (!RSTN) PSLVERR);
endmodule

// ===== verification/ana_host.sv
// Host model issuing APB transfers
`timescale 1ns/1ps
module ana_host (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e, output logic t);
    int n;
    n = 0;
    // One idle edge keeps back-to-back calls from driving a line twice
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    t = (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // Released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ===== verification/ana_adv_regs_tb.sv
// Self-checking bench of the advertisement register
`timescale 1ns/1ps
module ana_adv_regs_tb;
  logic clk = 0;
  logic rstn = 0;
  logic sel, en, wr, rdy, err, ra, e, f1, h1, f0, h0, rf;
  logic [11:0] a;
  logic [31:0] wd, rd, r;
  logic [15:0] act;
  int errors = 0;
  int checks = 0;
  always #4 clk = ~clk;
  ana_host u_host (.clk(clk), .pready(rdy), .pslverr(err), .prdata(rd), .psel(sel),
    .penable(en), .pwrite(wr), .paddr(a), .pwdata(wd));
  ana_adv_regs u_dut (.CLOCK(clk), .RSTN(rstn), .PSEL(sel), .PENABLE(en), .PWRITE(wr),
    .PADDR(a), .PWDATA(wd), .PRDATA(rd), .PREADY(rdy), .PSLVERR(err), .ADV_ACTIVE(act),
    .ADV_100TX_FULL(f1), .ADV_100TX_HALF(h1), .ADV_10T_FULL(f0), .ADV_10T_HALF(h0),
    .REMOTE_FAULT_ADVERT(rf), .RESTART_AUTONEG(ra));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic io(input logic w, input logic [11:0] ad, input logic [31:0] d);
    logic t;
    u_host.xfer(w, ad, d, r, e, t);
    if (t) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic restart();
    int n;
    n = 0;
    io(1, 12'h000, 32'h00000200);
    while (ra !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    if (ra !== 1'b1) begin
      errors++;
      finish_test();
    end
    @(posedge clk);
    chk({31'h0, ra}, 32'h00000000);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    io(0, 12'h010, 0);
    chk(r, 32'h000001e1);
    chk({16'h0, act}, 32'h000001e1);
    $display("reset test done");
    io(1, 12'h010, 32'hffffffff);
    io(0, 12'h010, 0);
    chk(r, 32'h000021e1);
    chk({16'h0, act}, 32'h000001e1);
    restart();
    chk({16'h0, act}, 32'h000021e1);
    chk({27'h0, rf, f1, h1, f0, h0}, 32'h0000001f);
    $display("write and restart test done");
    io(1, 12'h010, 32'h000000c0);
    chk({31'h0, f1}, 32'h00000001);
    restart();
    chk({27'h0, rf, f1, h1, f0, h0}, 32'h00000006);
    $display("mode removal test done");
    io(1, 12'h020, 32'hffffffff);
    chk({31'h0, e}, 32'h00000001);
    io(0, 12'h020, 0);
    chk(r, 32'h00000000);
    io(0, 12'h010, 0);
    chk(r, 32'h000000c1);
    $display("unmapped test done");
    finish_test();
  end
endmodule
